//--- hdl/jtc_defines.vh
// shared constants of the test access port controller
`ifndef JTC_DEFINES_VH
`define JTC_DEFINES_VH
// instruction chain length and instruction codes
`define JTC_IR_WIDTH 4
`define JTC_INS_EXTEST 4'h0
`define JTC_INS_INTEST 4'h1
`define JTC_INS_SAMPLE 4'h2
`define JTC_INS_DBG_ABORT 4'h8
`define JTC_INS_DBG_DPACC 4'ha
`define JTC_INS_DBG_APACC 4'hb
`define JTC_INS_IDCODE 4'he
`define JTC_INS_BYPASS 4'hf
// value captured into the instruction chain, two low bits fixed at 01
`define JTC_IR_CAPTURE 4'h1
// consecutive tms-high edges that force test-logic-reset
`define JTC_RESET_TMS_EDGES 5
// port-mux code for the test function, and pad defaults after reset
`define JTC_PORT_MUX_CODE 4'h3
`define JTC_PAD_PULLUP_RESET 4'hf
`define JTC_PAD_PULLDOWN_RESET 4'h0
`define JTC_PAD_ALTFUNC_RESET 4'hf
// tap states, one-hot
`define JTC_ST_TLR 16'h0001
`define JTC_ST_RTI 16'h0002
`define JTC_ST_SELDR 16'h0004
`define JTC_ST_CAPDR 16'h0008
`define JTC_ST_SHDR 16'h0010
`define JTC_ST_EX1DR 16'h0020
`define JTC_ST_PAUDR 16'h0040
`define JTC_ST_EX2DR 16'h0080
`define JTC_ST_UPDR 16'h0100
`define JTC_ST_SELIR 16'h0200
`define JTC_ST_CAPIR 16'h0400
`define JTC_ST_SHIR 16'h0800
`define JTC_ST_EX1IR 16'h1000
`define JTC_ST_PAUIR 16'h2000
`define JTC_ST_EX2IR 16'h4000
`define JTC_ST_UPIR 16'h8000
`endif

//--- hdl/jtc_tck_sync.v
// two-flop synchroniser and edge finder for the test clock and data pins
`timescale 1ns/100ps
module jtc_tck_sync
(
   input wire clk, // system clock
   input wire reset, // synchronous reset, active high
   input wire tckPin, // test clock pin
   input wire tmsPin, // mode select pin
   input wire tdiPin, // data in pin
   output reg tckRise, // one-cycle pulse on test clock rising edge
   output reg tckFall, // one-cycle pulse on test clock falling edge
   output reg tmsSync, // synchronised mode select
   output reg tdiSync // synchronised data in
);
   reg [2:0] meta_q;
   reg [2:0] sync_q;
   reg tckLast_q;
   // =====================================================
   // synchroniser
   // first stage feeds only the second stage; tms and tdi were settled
   // half a test clock before the rising edge, so sampling them alongside
   // the clock gives the value the host meant
   always @(posedge clk)
   begin
      if (reset)
      begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
         tckLast_q <= 1'b0;
         tckRise <= 1'b0;
         tckFall <= 1'b0;
         tmsSync <= 1'b1;
         tdiSync <= 1'b1;
      end
      else
      begin
         meta_q <= {tdiPin, tmsPin, tckPin};
         sync_q <= meta_q;
         tckLast_q <= sync_q[0];
         tckRise <= sync_q[0] & ~tckLast_q;
         tckFall <= ~sync_q[0] & tckLast_q;
         tmsSync <= sync_q[1];
         tdiSync <= sync_q[2];
      end
   end
endmodule

//--- hdl/jtc_tap_controller.v
// test access port controller: tap state machine, chains, tdo mux, pad defaults
// How it works
// - tap state advances on tms sampled at each test clock rising edge.
// - tap state decides capture, shift and update of the selected chain.
// - tap state selects instruction chain or data chain per phase.
// - the updated instruction picks which data chain is used.
// - extest and intest act on held data; no data chain captures, shifts or updates.
// - unknown instruction codes decode as bypass so a path always exists.
// - pin setup resets on either reset; test logic only on power-on.
// - after reset, pull-ups on, pull-downs off, tdo output left undriven.
// - a stopped test clock leaves state and registers untouched.
// - five tms-high rising edges reach test-logic-reset from any state.
// - entering test-logic-reset restores all chains and registers to defaults.
// - tdi sampled on rising edge goes into the currently selected chain.
// - tdo changes on the falling test clock edge.
// - tdo is not driven unless shifting chain data out.
// - power-on reset forces the tap straight into test-logic-reset.
// - pins leave reset in test function, port-mux code three.
// - the instruction chain is four bits long.
// - bypass, idcode, sample/preload, extest and intest are supported.
// - tdo mux picks core debug output or own chain per instruction.
`timescale 1ns/100ps
`include "jtc_defines.vh"
module jtc_tap_controller
#(
   parameter BSR_LEN = 8, // boundary chain length
   parameter [31:0] ID_VALUE = 32'h00000001 // identity code, arbitrary value
)
(
   input wire clk, // system clock, 250 MHz
   input wire reset, // power-on reset, synchronous, active high
   input wire extResetN, // external reset pin, active low
   input wire tckPin, // test clock pin
   input wire tmsPin, // mode select pin
   input wire tdiPin, // data in pin
   input wire coreTdo, // core debug controller data out
   input wire [BSR_LEN-1:0] pinSample, // pin levels seen by the boundary chain
   output reg tdoOut, // data out level
   output reg tdoOe, // data out driver enable
   output reg coreSelect, // high while a core debug instruction is loaded
   output reg [BSR_LEN-1:0] bsrUpdate, // boundary update register
   output reg extestActive, // boundary drives pins
   output reg intestActive, // boundary drives core
   output reg [3:0] pullUpEn, // pad pull-ups, tck tms tdi tdo
   output reg [3:0] pullDownEn, // pad pull-downs
   output reg [3:0] alternate_function_select_bit, // pads on test function
   output reg [3:0] port_mux_code_field, // mux code of test pads
   output reg [15:0] tapState // tap state, one-hot
);
   // state codes are one-hot, so each state test is a single flop
   localparam ST_TLR = `JTC_ST_TLR;
   localparam ST_RTI = `JTC_ST_RTI;
   localparam ST_SELDR = `JTC_ST_SELDR;
   localparam ST_CAPDR = `JTC_ST_CAPDR;
   localparam ST_SHDR = `JTC_ST_SHDR;
   localparam ST_EX1DR = `JTC_ST_EX1DR;
   localparam ST_PAUDR = `JTC_ST_PAUDR;
   localparam ST_EX2DR = `JTC_ST_EX2DR;
   localparam ST_UPDR = `JTC_ST_UPDR;
   localparam ST_SELIR = `JTC_ST_SELIR;
   localparam ST_CAPIR = `JTC_ST_CAPIR;
   localparam ST_SHIR = `JTC_ST_SHIR;
   localparam ST_EX1IR = `JTC_ST_EX1IR;
   localparam ST_PAUIR = `JTC_ST_PAUIR;
   localparam ST_EX2IR = `JTC_ST_EX2IR;
   localparam ST_UPIR = `JTC_ST_UPIR;
   localparam IRW = `JTC_IR_WIDTH;

   // edge pulses and synchronised pin levels from the pin front end
   wire tckRise;
   wire tckFall;
   wire tms;
   wire tdi;
   reg [1:0] rstMeta_q;
   reg [BSR_LEN-1:0] pinMeta_q;
   reg [BSR_LEN-1:0] pinSync_q;
   reg [15:0] state_d;
   reg [IRW-1:0] irShift_q;
   reg [IRW-1:0] irHold_q;
   reg [31:0] idShift_q;
   reg [BSR_LEN-1:0] bsrShift_q;
   reg bypass_q;
   reg [IRW-1:0] ins_d;
   reg selIr;
   reg chainOut;
   reg holdData;

   // =====================================================
   // pin synchroniser and test clock edge finder
   jtc_tck_sync u_sync
   (
      .clk(clk),
      .reset(reset),
      .tckPin(tckPin),
      .tmsPin(tmsPin),
      .tdiPin(tdiPin),
      .tckRise(tckRise),
      .tckFall(tckFall),
      .tmsSync(tms),
      .tdiSync(tdi)
   );

   // =====================================================
   // instruction decode
   // codes outside the known set fall back to bypass
   // core debug codes pass through, so the tdo mux can hand the pin over;
   // the list is explicit so a new code cannot slip past the bypass default
   always @*
   begin
      case (irHold_q)
         `JTC_INS_EXTEST, `JTC_INS_INTEST, `JTC_INS_SAMPLE, `JTC_INS_IDCODE,
         `JTC_INS_DBG_ABORT, `JTC_INS_DBG_DPACC, `JTC_INS_DBG_APACC:
            ins_d = irHold_q;
         default:
            ins_d = `JTC_INS_BYPASS;
      endcase
      // extest/intest work on held data, chains frozen
      holdData = (ins_d == `JTC_INS_EXTEST) || (ins_d == `JTC_INS_INTEST);
   end

   // =====================================================
   // tap next state
   // pause states let a host stall a long shift without losing bits
   always @*
   begin
      case (tapState)
         ST_TLR: state_d = tms ? ST_TLR : ST_RTI;
         ST_RTI: state_d = tms ? ST_SELDR : ST_RTI;
         ST_SELDR: state_d = tms ? ST_SELIR : ST_CAPDR;
         ST_CAPDR: state_d = tms ? ST_EX1DR : ST_SHDR;
         ST_SHDR: state_d = tms ? ST_EX1DR : ST_SHDR;
         ST_EX1DR: state_d = tms ? ST_UPDR : ST_PAUDR;
         ST_PAUDR: state_d = tms ? ST_EX2DR : ST_PAUDR;
         ST_EX2DR: state_d = tms ? ST_UPDR : ST_SHDR;
         ST_UPDR: state_d = tms ? ST_SELDR : ST_RTI;
         ST_SELIR: state_d = tms ? ST_TLR : ST_CAPIR;
         ST_CAPIR: state_d = tms ? ST_EX1IR : ST_SHIR;
         ST_SHIR: state_d = tms ? ST_EX1IR : ST_SHIR;
         ST_EX1IR: state_d = tms ? ST_UPIR : ST_PAUIR;
         ST_PAUIR: state_d = tms ? ST_EX2IR : ST_PAUIR;
         ST_EX2IR: state_d = tms ? ST_UPIR : ST_SHIR;
         ST_UPIR: state_d = tms ? ST_SELDR : ST_RTI;
         default: state_d = ST_TLR;
      endcase
   end

   // =====================================================
   // external reset pin synchroniser, feeds pad setup only
   // the pin falls at any time, so only the second flop is ever read
   always @(posedge clk)
   begin
      if (reset)
         rstMeta_q <= 2'h0;
      else
         rstMeta_q <= {rstMeta_q[0], ~extResetN};
   end

   // =====================================================
   // boundary sample synchroniser
   // pin levels come from outside the clock domain; two flops before capture,
   // costing two system clocks that a test clock period easily hides
   always @(posedge clk)
   begin
      pinMeta_q <= pinSample;
      pinSync_q <= pinMeta_q;
   end

   // =====================================================
   // pad configuration, reset by either source
   // there is no write path, so the setup only ever holds its reset values;
   // the tap is left out on purpose, since only power-on may touch it
   always @(posedge clk)
   begin
      if (reset || rstMeta_q[1])
      begin
         pullUpEn <= `JTC_PAD_PULLUP_RESET;
         pullDownEn <= `JTC_PAD_PULLDOWN_RESET;
         alternate_function_select_bit <= `JTC_PAD_ALTFUNC_RESET;
         port_mux_code_field <= `JTC_PORT_MUX_CODE;
      end
   end

   // =====================================================
   // tap state and chains, power-on reset only, move only on a tck rise
   // nothing here changes without a rising edge, so a parked clock holds all
   // limitation: tck phases shorter than one system clock can be missed
   always @(posedge clk)
   begin
      if (reset)
      begin
         tapState <= ST_TLR;
         irShift_q <= `JTC_IR_CAPTURE;
         irHold_q <= `JTC_INS_IDCODE;
         idShift_q <= 32'h00000000;
         bsrShift_q <= {BSR_LEN{1'b0}};
         bsrUpdate <= {BSR_LEN{1'b0}};
         bypass_q <= 1'b0;
      end
      else if (tckRise)
      begin
         tapState <= state_d;
         // defaults land on the rise that enters test-logic-reset, and again
         // on every rise while parked there; no other branch can fire then
         if (state_d == ST_TLR)
         begin
            irHold_q <= `JTC_INS_IDCODE;
            irShift_q <= `JTC_IR_CAPTURE;
            idShift_q <= 32'h00000000;
            bsrShift_q <= {BSR_LEN{1'b0}};
            bsrUpdate <= {BSR_LEN{1'b0}};
            bypass_q <= 1'b0;
         end
         // instruction path
         // the ir chain always shifts, even while extest or intest holds the data
         if (tapState == ST_CAPIR)
            irShift_q <= `JTC_IR_CAPTURE;
         if (tapState == ST_SHIR)
            irShift_q <= {tdi, irShift_q[IRW-1:1]};
         if (tapState == ST_UPIR)
            irHold_q <= irShift_q;
         // data path, chain chosen by instruction
         if (!holdData)
         begin
            case (ins_d)
               `JTC_INS_IDCODE:
               begin
                  if (tapState == ST_CAPDR)
                     idShift_q <= ID_VALUE;
                  else if (tapState == ST_SHDR)
                     idShift_q <= {tdi, idShift_q[31:1]};
               end
               `JTC_INS_SAMPLE:
               begin
                  if (tapState == ST_CAPDR)
                     bsrShift_q <= pinSync_q;
                  else if (tapState == ST_SHDR)
                     bsrShift_q <= {tdi, bsrShift_q[BSR_LEN-1:1]};
                  else if (tapState == ST_UPDR)
                     bsrUpdate <= bsrShift_q;
               end
               default:
               begin
                  if (tapState == ST_CAPDR)
                     bypass_q <= 1'b0;
                  else if (tapState == ST_SHDR)
                     bypass_q <= tdi;
               end
            endcase
         end
      end
   end

   // =====================================================
   // serial output selection
   // the instruction chain wins in shift-ir, else the decoded data chain
   always @*
   begin
      selIr = (tapState == ST_SHIR);
      case (ins_d)
         `JTC_INS_IDCODE: chainOut = idShift_q[0];
         `JTC_INS_SAMPLE: chainOut = bsrShift_q[0];
         default: chainOut = bypass_q;
      endcase
      if (selIr)
         chainOut = irShift_q[0];
   end

   // =====================================================
   // tdo pin, updated only on the falling tck edge so a downstream part
   // samples a settled value on the next rise
   // the enable drops at the first fall after a shift state is left;
   // core debug codes hand the pin to the core everywhere but shift-ir
   always @(posedge clk)
   begin
      if (reset)
      begin
         tdoOut <= 1'b1;
         tdoOe <= 1'b0;
         coreSelect <= 1'b0;
         extestActive <= 1'b0;
         intestActive <= 1'b0;
      end
      else
      begin
         extestActive <= (ins_d == `JTC_INS_EXTEST);
         intestActive <= (ins_d == `JTC_INS_INTEST);
         if (tckFall)
         begin
            coreSelect <= (ins_d == `JTC_INS_DBG_ABORT) ||
               (ins_d == `JTC_INS_DBG_DPACC) || (ins_d == `JTC_INS_DBG_APACC);
            tdoOe <= selIr || (tapState == ST_SHDR && !holdData);
            if (!selIr && ((ins_d == `JTC_INS_DBG_ABORT) ||
               (ins_d == `JTC_INS_DBG_DPACC) || (ins_d == `JTC_INS_DBG_APACC)))
               tdoOut <= coreTdo;
            else
               tdoOut <= chainOut;
         end
      end
   end
endmodule

//--- test/jtc_tap_asserts.sv
// port checker of the test access port controller
`timescale 1ns/100ps
`include "jtc_defines.vh"
module jtc_tap_asserts
#(
   parameter BSR_LEN = 8
)
(
   input wire clk, // clock
   input wire reset, // power-on reset
   input wire extResetN, // pin reset
   input wire tckPin, // test clock
   input wire tmsPin, // mode select
   input wire tdoOut, // data out
   input wire tdoOe, // out enable
   input wire [BSR_LEN-1:0] bsrUpdate, // update reg
   input wire extestActive, // extest
   input wire intestActive, // intest
   input wire [3:0] pullUpEn, // pull-ups
   input wire [3:0] pullDownEn, // pull-downs
   input wire [3:0] alternate_function_select_bit, // alt function
   input wire [3:0] port_mux_code_field, // mux code
   input wire [15:0] tapState // state
);
   // ==========
   // own edge finder, so design timing is judged apart from its own
   reg [2:0] tckQ;
   reg [1:0] tmsQ;
   reg [3:0] riseAge;
   reg [3:0] fallAge;
   reg [2:0] onesQ;
   wire rise = tckQ[1] & ~tckQ[2];
   wire fall = ~tckQ[1] & tckQ[2];
   wire padOk = {pullUpEn, pullDownEn, alternate_function_select_bit, port_mux_code_field}
      == {`JTC_PAD_PULLUP_RESET, `JTC_PAD_PULLDOWN_RESET, `JTC_PAD_ALTFUNC_RESET,
      `JTC_PORT_MUX_CODE};
   // ages saturate so a stopped clock reads as long ago
   always @(posedge clk)
   begin
      tckQ <= {tckQ[1:0], tckPin};
      tmsQ <= {tmsQ[0], tmsPin};
      if (reset)
      begin
         riseAge <= 4'hf;
         fallAge <= 4'hf;
         onesQ <= 3'h0;
      end
      else
      begin
         riseAge <= rise ? 4'h0 : riseAge + {3'h0, riseAge != 4'hf};
         fallAge <= fall ? 4'h0 : fallAge + {3'h0, fallAge != 4'hf};
         if (rise)
            onesQ <= tmsQ[1] ? onesQ + {2'h0, onesQ != 3'h7} : 3'h0;
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_fifth_high;
      rise && tmsQ[1] && onesQ == 3'h4;
   endsequence
   sequence s_leave_reset;
      tapState == `JTC_ST_TLR && rise && !tmsQ[1];
   endsequence
   property p_reset_defaults;
      $fell(reset) |-> tapState == `JTC_ST_TLR && padOk && !tdoOe;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset state");
   property p_ext_pads;
      $fell(extResetN) |-> ##[1:6] padOk;
   endproperty
   a_ext_pads: assert property (p_ext_pads) else $error("pads not at defaults");
   property p_moves_on_rise;
      $changed(tapState) |-> riseAge <= 4'h3;
   endproperty
   a_moves_on_rise: assert property (p_moves_on_rise) else $error("state moved idle");
   property p_five_high;
      s_fifth_high |-> ##[1:5] tapState == `JTC_ST_TLR;
   endproperty
   a_five_high: assert property (p_five_high) else $error("no test-logic-reset");
   property p_idle_step;
      s_leave_reset |-> ##[1:5] tapState == `JTC_ST_RTI;
   endproperty
   a_idle_step: assert property (p_idle_step) else $error("bad step to idle");
   property p_tdo_on_fall;
      $changed(tdoOut) || $changed(tdoOe) |-> fallAge <= 4'h3;
   endproperty
   a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo off fall");
   property p_oe_in_shift;
      tdoOe |-> (tapState & (`JTC_ST_SHDR | `JTC_ST_EX1DR | `JTC_ST_SHIR | `JTC_ST_EX1IR)) != 0;
   endproperty
   a_oe_in_shift: assert property (p_oe_in_shift) else $error("tdo driven idle");
   property p_test_hold;
      extestActive || intestActive |-> $stable(bsrUpdate)
         && !(tdoOe && tapState == `JTC_ST_SHDR);
   endproperty
   a_test_hold: assert property (p_test_hold) else $error("chain moved in test");
endmodule
bind jtc_tap_controller jtc_tap_asserts #(.BSR_LEN(BSR_LEN)) u_asserts
(
   .clk(clk), .reset(reset), .extResetN(extResetN), .tckPin(tckPin), .tmsPin(tmsPin),
   .tdoOut(tdoOut), .tdoOe(tdoOe), .bsrUpdate(bsrUpdate), .extestActive(extestActive),
   .intestActive(intestActive), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
   .alternate_function_select_bit(alternate_function_select_bit),
   .port_mux_code_field(port_mux_code_field), .tapState(tapState)
);

//--- test/jtc_jtag_host.sv
// model of the external test host on the tap pins
`timescale 1ns/100ps
module jtc_jtag_host
(
   output logic tckPin, // test clock
   output logic tmsPin, // mode select
   output logic tdiPin, // data in
   input wire tdoOut, // data out
   input wire tdoOe // out enable
);
   // tdo pad keeps its pull-up, so an undriven pin reads high
   wire tdoWire = tdoOe ? tdoOut : 1'b1;
   initial
   begin
      tckPin = 1'b0;
      tmsPin = 1'b1;
      tdiPin = 1'b1;
   end
   // one clock; levels move at the fall, tdo read late since it lags the fall
   task automatic bit_clk(input logic tms, input logic tdi, output logic tdo);
   begin
      tmsPin = tms;
      tdiPin = tdi;
      #16 tckPin = 1'b1;
      #15 tdo = tdoWire;
      #1 tckPin = 1'b0;
   end
   endtask
   // five tms-high clocks, then idle
   task automatic tap_reset;
      logic t;
   begin
      repeat (5) bit_clk(1'b1, 1'b1, t);
      bit_clk(1'b0, 1'b1, t);
   end
   endtask
   // from idle: capture, shift n bits lsb first, update, back to idle
   task automatic scan(input logic isIr, input logic [31:0] din, input int n,
      output logic [31:0] dout);
      logic t;
   begin
      dout = '0;
      bit_clk(1'b1, 1'b1, t);
      if (isIr)
         bit_clk(1'b1, 1'b1, t);
      bit_clk(1'b0, 1'b1, t);
      bit_clk(1'b0, 1'b1, t);
      for (int i = 0; i < n; i++)
         bit_clk(i == n - 1, din[i], dout[i]);
      bit_clk(1'b1, 1'b1, t);
      bit_clk(1'b0, 1'b1, t);
   end
   endtask
endmodule

//--- test/tb_jtag_tap_controller.sv
// self-checking bench of the test access port controller
`timescale 1ns/100ps
`include "jtc_defines.vh"
module tb_jtag_tap_controller;
   localparam [31:0] TB_ID = 32'h5a3c0e71; // arbitrary identity value
   localparam int LIMIT = 30000;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic extResetN = 1'b1;
   logic coreTdo = 1'b0;
   logic [7:0] pinSample = 8'h00;
   wire tckPin, tmsPin, tdiPin, tdoOut, tdoOe, coreSelect, extestActive, intestActive;
   wire [7:0] bsrUpdate;
   wire [3:0] pullUpEn, pullDownEn, altFn, muxCode;
   wire [15:0] tapState;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   int seed = 48;
   logic [31:0] dout;
   logic [31:0] rnd;
   logic [7:0] held;
   always #2 clk = ~clk;
   jtc_tap_controller #(.BSR_LEN(8), .ID_VALUE(TB_ID)) u_dut
   (
      .clk(clk), .reset(reset), .extResetN(extResetN), .tckPin(tckPin), .tmsPin(tmsPin),
      .tdiPin(tdiPin), .coreTdo(coreTdo), .pinSample(pinSample), .tdoOut(tdoOut),
      .tdoOe(tdoOe), .coreSelect(coreSelect), .bsrUpdate(bsrUpdate),
      .extestActive(extestActive), .intestActive(intestActive), .pullUpEn(pullUpEn),
      .pullDownEn(pullDownEn), .alternate_function_select_bit(altFn),
      .port_mux_code_field(muxCode), .tapState(tapState)
   );
   jtc_jtag_host u_host
   (
      .tckPin(tckPin), .tmsPin(tmsPin), .tdiPin(tdiPin), .tdoOut(tdoOut), .tdoOe(tdoOe)
   );
   // ==========
   // checking and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task automatic final_report;
   begin
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // data chain read-out over eight clocks for one instruction
   function automatic logic [7:0] exp_dr(input logic [3:0] c, input logic [7:0] d);
   begin
      case (c)
         4'h0, 4'h1: exp_dr = 8'hff; // undriven, pull-up shows
         4'h2: exp_dr = pinSample;
         4'h8, 4'ha, 4'hb: exp_dr = {8{coreTdo}};
         4'he: exp_dr = TB_ID[7:0];
         default: exp_dr = {d[6:0], 1'b0};
      endcase
   end
   endfunction
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         miscompares++;
         final_report;
      end
   end
   // ==========
   // main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      #1 reset = 1'b0;
      @(posedge clk);
      #1 check({pullUpEn, pullDownEn, altFn, muxCode}, 16'hf0f3);
      check(tdoOe, 1'b0);
      u_host.tap_reset();
      held = 8'h00;
      // every code from the top, so the preload lands before extest and intest
      for (int c = 15; c >= 0; c--)
      begin
         @(posedge clk);
         rnd = $random(seed);
         #1 coreTdo = rnd[16];
         pinSample = rnd[7:0];
         u_host.scan(1'b1, c, 4, dout);
         check(dout[3:0], 4'h1);
         u_host.scan(1'b0, rnd[15:8], 8, dout);
         check(dout[7:0], exp_dr(c, rnd[15:8]));
         if (c == 2)
            held = rnd[15:8];
         repeat (4 + rnd[29:24]) @(posedge clk);
         #1 check(tapState, `JTC_ST_RTI);
         check(coreSelect, c == 8 || c == 10 || c == 11);
         check(extestActive, c == 0);
         check(intestActive, c == 1);
         if (c <= 2)
            check(bsrUpdate, held);
      end
      // pin reset must leave the tap and its instruction alone
      u_host.scan(1'b1, 32'h8, 4, dout);
      @(posedge clk);
      #1 extResetN = 1'b0;
      repeat (8) @(posedge clk);
      #1 extResetN = 1'b1;
      repeat (8) @(posedge clk);
      #1 check(tapState, `JTC_ST_RTI);
      check(coreSelect, 1'b1);
      // park in shift-dr; five tms-high clocks restore the identity chain
      u_host.bit_clk(1'b1, 1'b0, dout[0]);
      u_host.bit_clk(1'b0, 1'b0, dout[0]);
      u_host.bit_clk(1'b0, 1'b0, dout[0]);
      u_host.tap_reset();
      u_host.scan(1'b0, 32'h0, 32, dout);
      check(dout, TB_ID);
      // identity read with a pause after four bits; no bit may be lost
      u_host.bit_clk(1'b1, 1'b0, dout[8]);
      u_host.bit_clk(1'b0, 1'b0, dout[8]);
      u_host.bit_clk(1'b0, 1'b0, dout[8]);
      for (int i = 0; i < 8; i++)
      begin
         u_host.bit_clk(i == 3 || i == 7, 1'b0, dout[i]);
         if (i == 3)
         begin
            u_host.bit_clk(1'b0, 1'b0, dout[8]);
            repeat (8) @(posedge clk);
            #1 check(tapState, `JTC_ST_PAUDR);
            check(tdoOe, 1'b0);
            u_host.bit_clk(1'b1, 1'b0, dout[8]);
            u_host.bit_clk(1'b0, 1'b0, dout[8]);
         end
      end
      u_host.bit_clk(1'b1, 1'b0, dout[8]);
      u_host.bit_clk(1'b0, 1'b0, dout[8]);
      check(dout[7:0], TB_ID[7:0]);
      // power-on reset in mid instruction shift
      u_host.bit_clk(1'b1, 1'b0, dout[0]);
      u_host.bit_clk(1'b1, 1'b0, dout[0]);
      u_host.bit_clk(1'b0, 1'b0, dout[0]);
      u_host.bit_clk(1'b0, 1'b0, dout[0]);
      // pause the instruction shift and come back to shift-ir
      u_host.bit_clk(1'b1, 1'b0, dout[0]);
      u_host.bit_clk(1'b0, 1'b0, dout[0]);
      u_host.bit_clk(1'b1, 1'b0, dout[0]);
      u_host.bit_clk(1'b0, 1'b0, dout[0]);
      repeat (8) @(posedge clk);
      #1 check(tapState, `JTC_ST_SHIR);
      check(tdoOe, 1'b1);
      reset = 1'b1;
      repeat (3) @(posedge clk);
      #1 reset = 1'b0;
      @(posedge clk);
      #1 check(tapState, `JTC_ST_TLR);
      check(tdoOe, 1'b0);
      final_report;
   end
endmodule
